// File: bench/reed_solomon_decoder_config_tb.sv
// Self-checking bench for the Reed-Solomon decoder
`default_nettype none
`define CHK(what, exp, seen) begin checks++; if ((seen) !== (exp)) begin mismatches++; \
   $display("ERROR %s expected %0h seen %0h", what, exp, seen); end end
module reed_solomon_decoder_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, nrst, clk_en, var_len, out_parity, slow;
   logic ctrl_valid, ctrl_ready, ctrl_invalid, in_valid, in_ready, out_valid, out_ready;
   logic [3:0]             code_sel;
   rs_types_pkg::ctrl_type ctrl_data;
   rs_types_pkg::in_type   in_data;
   rs_types_pkg::out_type  out_data;
   rs_types_pkg::out_type  got[$];
   int                     checks, mismatches;
   rs_decoder dut (.ref_clk, .nrst, .clk_en, .code_sel, .var_len, .out_parity, .ctrl_valid,
      .ctrl_ready, .ctrl_data, .ctrl_invalid, .in_valid, .in_ready, .in_data, .out_valid,
      .out_ready, .out_data);
   rs_sink_model sink (.ref_clk, .nrst, .slow, .out_valid, .out_ready);
   // ----------------------------------------
   // Clock and collection of decoded words
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_data);
   end
   // ----------------------------------------
   // Drivers and block check
   // ----------------------------------------
   // Zero codeword with one bad symbol; clock enable dropped now and then
   task automatic send_block(input int n, ep, xp, input rs_types_pkg::sym_type ev);
      for (int i = 0; i < n; i++) begin
         if (i % 50 == 7) begin
            clk_en <= 1'b0;
            @(posedge ref_clk);
            clk_en <= 1'b1;
         end
         in_valid <= 1'b1;
         in_data <= '{sym: (i == ep) ? ev : 8'h00, erase: i == xp, mark: i[1:0]};
         do @(posedge ref_clk); while (in_ready !== 1'b1);
      end
      in_valid <= 1'b0;
      in_data <= ~in_data;
   endtask
   task automatic check_block(input int cnt, k, ep, o2z, ecnt, input rs_types_pkg::sym_type ev);
      rs_types_pkg::out_type w;
      for (int t = 0; t < 20000 && got.size() < cnt; t++) @(posedge ref_clk);
      `CHK("word count", cnt, got.size())
      for (int i = 0; i < got.size(); i++) begin
         w = got[i];
         `CHK("symbol", 8'h00, w.sym)
         `CHK("marker", i[1:0], w.mark)
         `CHK("channel", 7'h00, w.chan)
         `CHK("info flag", i == k - 1, w.info_last)
         `CHK("last flag", i == cnt - 1, w.last)
         `CHK("received copy", (i == ep) ? ev : 8'h00, w.delayed_received_field)
      end
      `CHK("fail flag", 1'b0, w.fail)
      `CHK("one to zero", o2z, w.one_to_zero_corrections)
      `CHK("zero to one", 9'h000, w.zero_to_one_corrections)
      if (ecnt >= 0) `CHK("error count", ecnt, w.err_cnt)
      got = {};
   endtask
   // Two-cycle reset: with fixed length an idle decoder restarts at once
   task automatic pulse_reset;
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Custom code, info symbols only, prompt sink
   task automatic t_custom_info;
      send_block(255, 5, -1, 8'h5a);
      check_block(239, 239, 5, 4, 1, 8'h5a);
      $display("test custom_info done");
   endtask
   // Preset (204,188) with parity out, erasure, slow sink fills the buffer
   task automatic t_preset_parity;
      code_sel <= 4'h1;
      out_parity <= 1'b1;
      slow <= 1'b1;
      pulse_reset();
      send_block(204, 0, 200, 8'h0f);
      check_block(204, 188, 0, 4, -1, 8'h0f);
      $display("test preset_parity done");
   endtask
   // Illegal control word refused, then a shortened block by control word
   task automatic t_ctrl_word;
      logic seen;
      code_sel <= 4'h0;
      out_parity <= 1'b0;
      slow <= 1'b0;
      var_len <= 1'b1;
      pulse_reset();
      ctrl_data <= '{n: 8'h02, r: 6'h04, punct: 4'h0};
      ctrl_valid <= 1'b1;
      do @(posedge ref_clk); while (ctrl_ready !== 1'b1);
      ctrl_valid <= 1'b0;
      seen = 1'b0;
      repeat (4) begin
         @(posedge ref_clk);
         seen |= (ctrl_invalid === 1'b1);
      end
      `CHK("invalid flag", 1'b1, seen)
      ctrl_data <= '{n: 8'h14, r: 6'h04, punct: 4'h0};
      ctrl_valid <= 1'b1;
      do @(posedge ref_clk); while (ctrl_ready !== 1'b1);
      ctrl_valid <= 1'b0;
      send_block(20, 19, -1, 8'hff);
      check_block(16, 16, 19, 8, 1, 8'hff);
      $display("test ctrl_word done");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Reset held ten cycles, then the scenarios in turn
   initial begin
      {nrst, var_len, out_parity, slow, ctrl_valid, in_valid} = 6'h00;
      clk_en = 1'b1;
      code_sel = 4'h0;
      ctrl_data = '0;
      in_data = '0;
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      t_custom_info();
      t_preset_parity();
      t_ctrl_word();
      complete_run();
   end
   // Three blocks plus slow draining need far fewer cycles than this
   initial begin
      repeat (40000) @(posedge ref_clk);
      mismatches++;
      complete_run();
   end
endmodule
`default_nettype wire

// File: bench/rs_decoder_asserts.sv
// Port checker for the Reed-Solomon decoder
`default_nettype none
module rs_decoder_asserts (
   // Clock, reset, configuration
   input wire logic                  ref_clk,
   input wire logic                  nrst,
   input wire logic                  clk_en,
   input wire logic                  var_len,
   input wire logic                  out_parity,
   // Stream handshakes
   input wire logic                  ctrl_valid,
   input wire logic                  ctrl_ready,
   input wire logic                  ctrl_invalid,
   input wire logic                  in_ready,
   input wire logic                  out_valid,
   input wire logic                  out_ready,
   input wire rs_types_pkg::out_type out_data
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // ----------------------------------------
   // Handshake and flag relations
   // ----------------------------------------
   chk_enable_gates_all: assert property (!clk_en
      |-> !in_ready && !out_valid && !ctrl_ready)
      else $error("stream active while clock enable low");
   chk_ctrl_needs_varlen: assert property (ctrl_ready |-> var_len)
      else $error("control channel ready without variable length");
   chk_ctrl_answer: assert property (ctrl_valid && ctrl_ready
      |=> in_ready || ctrl_invalid)
      else $error("control word taken but no answer");
   chk_invalid_pulse: assert property (ctrl_invalid |=> !ctrl_invalid)
      else $error("invalid flag longer than one cycle");
   chk_invalid_no_start: assert property (ctrl_invalid |-> !in_ready)
      else $error("block started after illegal word");
   chk_out_hold: assert property (out_valid && !out_ready |=> $stable(out_data))
      else $error("output word changed while waiting");
   chk_info_is_last: assert property (out_valid && out_data.last && !out_parity
      |-> out_data.info_last)
      else $error("last word without info flag in info-only mode");
   chk_fail_clears_count: assert property (out_valid && out_data.fail
      |-> out_data.err_cnt == 6'h00)
      else $error("failed block reports corrections");
   // Reset itself is the cause here, so this one is never disabled
   chk_reset_clears: assert property (disable iff (1'b0)
      !nrst |=> !out_valid && !in_ready && !ctrl_invalid)
      else $error("outputs active after reset");
   // Main scenarios reached
   cover property (ctrl_invalid);
   cover property (out_valid && !out_ready);
   cover property (out_valid && out_data.last && out_parity);
endmodule
bind rs_decoder rs_decoder_asserts chk (.ref_clk, .nrst, .clk_en, .var_len, .out_parity,
   .ctrl_valid, .ctrl_ready, .ctrl_invalid, .in_ready, .out_valid, .out_ready, .out_data);
`default_nettype wire

// File: bench/rs_sink_model.sv
// Downstream sink model, prompt or slow in taking decoded words
`default_nettype none
module rs_sink_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Mode and handshake
   input wire logic slow,
   input wire logic out_valid,
   output logic     out_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_q;
   // Phase steps while a word waits; slow mode takes one in four to fill the buffer
   always_ff @(posedge ref_clk) begin
      if (!nrst) phase_q <= 2'h0;
      else if (out_valid) phase_q <= phase_q + 2'h1;
   end
   assign out_ready = !slow || (phase_q == 2'h3);
endmodule
`default_nettype wire

// File: shared/rs_defines.svh
// Constants of the Reed-Solomon decoder: field, code limits, options
`ifndef RS_DEFINES_SVH
`define RS_DEFINES_SVH
`define RS_SYM_W 8
`define RS_DEF_POLY 285
`define RS_FIELD_POLY 0
`define RS_POLY ((`RS_FIELD_POLY == 0) ? `RS_DEF_POLY : `RS_FIELD_POLY)
`define RS_SCALE_H 1
`define RS_GEN_START 0
`define RS_MIN_N 3
`define RS_MAX_N 255
`define RS_MAX_R 32
`define RS_MIN_R 2
`define RS_DEF_N 255
`define RS_DEF_R 16
`define RS_MARK_W 2
`define RS_CHANNELS 1
`define RS_NUM_PUNCT 0
`define RS_NUM_RSUP 0
`define RS_RSUP_LIST {6'h0e, 6'h10, 6'h12, 6'h14}
`define RS_FIFO_DEPTH 8
`endif

// File: shared/rs_types_pkg.sv
// Types shared by the decoder, its port checker and its bench
`default_nettype none
`include "rs_defines.svh"
package rs_types_pkg;
   typedef logic [`RS_SYM_W-1:0] sym_type;
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_COLLECT = 3'b001,
      ST_BM      = 3'b010,
      ST_SCAN    = 3'b011,
      ST_EMIT    = 3'b100
   } state_type;
   typedef struct packed {
      logic [7:0] n;
      logic [5:0] r;
      logic [3:0] punct;
   } ctrl_type;
   typedef struct packed {
      sym_type                sym;
      logic                   erase;
      logic [`RS_MARK_W-1:0]  mark;
   } in_type;
   typedef struct packed {
      sym_type                sym;
      sym_type                delayed_received_field;
      logic [`RS_MARK_W-1:0]  mark;
      logic [6:0]             chan;
      logic                   info_last;
      logic                   last;
      logic                   fail;
      logic [5:0]             err_cnt;
      logic [8:0]             zero_to_one_corrections;
      logic [8:0]             one_to_zero_corrections;
   } out_type;
endpackage
`default_nettype wire

// File: verilog/rs_decoder.sv
// Reed-Solomon decoder: collect, Berlekamp-Massey, Chien/Forney, emit
//
// Operation
// - Symbol width fixed at eight, range 3-12
// - Field polynomial from config, zero picks default
// - Scaling factor must be coprime to field order
// - Generator roots alpha^(h(start+j))
// - Block length between 3 and field order
// - Information count between max(n-32,1), n-2
// - Preset code selections fix n and k
// - Variable length adds a control channel
// - Supported-count list length equals configured count; here the list holds 4 entries and RS_NUM_RSUP is 0
// - Illegal state resets the control machine
// - Blocks tagged with a channel number
// - Parity output gives n, else k symbols
// - Puncture pattern count zero disables puncturing
// - Clock enable gates every state update
// - Flag marks the last information symbol
// - Erase input marks a received erasure
// - Per-block counts of one-to-zero, zero-to-one fixes
// - Marker bits delayed with their symbols
// - Uncorrected symbols delivered alongside corrected
// - Correctable when 2*errors + erasures <= n-k
// - Fail flag on every output symbol of the block
`default_nettype none
`include "rs_defines.svh"
module rs_decoder (
   // Clock, reset, enable
   input  wire logic                      ref_clk,
   input  wire logic                      nrst,
   input  wire logic                      clk_en,
   // Static configuration
   input  wire logic [3:0]                code_sel,
   input  wire logic                      var_len,
   input  wire logic                      out_parity,
   // Control channel
   input  wire logic                      ctrl_valid,
   output logic                           ctrl_ready,
   input  wire rs_types_pkg::ctrl_type    ctrl_data,
   output logic                           ctrl_invalid,
   // Received symbol channel
   input  wire logic                      in_valid,
   output logic                           in_ready,
   input  wire rs_types_pkg::in_type      in_data,
   // Decoded symbol channel
   output logic                           out_valid,
   input  wire logic                      out_ready,
   output rs_types_pkg::out_type          out_data
);
   localparam int R = `RS_MAX_R;
   localparam rs_types_pkg::sym_type POLY8 = rs_types_pkg::sym_type'(`RS_POLY);

   // -----------------------------------------------------------------
   // Field arithmetic
   // -----------------------------------------------------------------
   function automatic rs_types_pkg::sym_type gf_mul(input rs_types_pkg::sym_type a,
                                                   input rs_types_pkg::sym_type b);
      rs_types_pkg::sym_type p;
      p = '0;
      for (int i = `RS_SYM_W - 1; i >= 0; i--) begin
         p = {p[`RS_SYM_W-2:0], 1'b0} ^ (p[`RS_SYM_W-1] ? POLY8 : '0);
         if (b[i]) p = p ^ a;
      end
      return p;
   endfunction

   function automatic rs_types_pkg::sym_type gf_pow(input rs_types_pkg::sym_type a,
                                                   input logic [7:0] e);
      rs_types_pkg::sym_type p;
      p = 8'h01;
      for (int i = 7; i >= 0; i--) begin
         p = gf_mul(p, p);
         if (e[i]) p = gf_mul(p, a);
      end
      return p;
   endfunction

   function automatic rs_types_pkg::sym_type gf_inv(input rs_types_pkg::sym_type a);
      return gf_pow(a, 8'hfe);
   endfunction

   function automatic logic [3:0] ones(input rs_types_pkg::sym_type a);
      logic [3:0] c;
      c = '0;
      for (int i = 0; i < `RS_SYM_W; i++) c = c + 4'(a[i]);
      return c;
   endfunction

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   rs_types_pkg::state_type state_q;
   rs_types_pkg::sym_type   rx_q   [0:`RS_MAX_N-1];
   rs_types_pkg::sym_type   fix_q  [0:`RS_MAX_N-1];
   logic [`RS_MARK_W-1:0]   mark_q [0:`RS_MAX_N-1];
   rs_types_pkg::sym_type   syn_q  [0:R-1];
   rs_types_pkg::sym_type   lam_q  [0:R];
   rs_types_pkg::sym_type   bb_q   [0:R];
   rs_types_pkg::sym_type   lt_q   [0:R];
   rs_types_pkg::sym_type   ot_q   [0:R-1];
   rs_types_pkg::sym_type   xinv_q;
   logic [7:0]              n_q;
   logic [5:0]              r_q;
   logic [7:0]              idx_q;
   logic [7:0]              ers_q;
   logic [5:0]              rr_q;
   logic [5:0]              len_q;
   logic [7:0]              roots_q;
   logic [8:0]              z2o_q;
   logic [8:0]              o2z_q;
   logic                    fail_q;
   logic [6:0]              chan_q;

   // -----------------------------------------------------------------
   // Code selection and control checks
   // -----------------------------------------------------------------
   logic [7:0] pre_n;
   logic [5:0] pre_r;
   always_comb begin
      case (code_sel)
         4'h1:    begin pre_n = 8'hcc; pre_r = 6'h10; end
         4'h2:    begin pre_n = 8'hcf; pre_r = 6'h14; end
         4'h3:    begin pre_n = 8'hff; pre_r = 6'h20; end
         4'h4:    begin pre_n = 8'hff; pre_r = 6'h10; end
         4'h5:    begin pre_n = 8'h7e; pre_r = 6'h0e; end
         4'h6:    begin pre_n = 8'hc2; pre_r = 6'h10; end
         4'h7:    begin pre_n = 8'hd0; pre_r = 6'h10; end
         4'h8:    begin pre_n = 8'hdb; pre_r = 6'h12; end
         4'h9:    begin pre_n = 8'he1; pre_r = 6'h14; end
         default: begin pre_n = 8'(`RS_DEF_N); pre_r = 6'(`RS_DEF_R); end
      endcase
   end

   // Control word carries length, check count and puncture pick
   wire [7:0] sel_n = var_len ? ctrl_data.n : pre_n;
   wire [5:0] sel_r = var_len ? ctrl_data.r : pre_r;
   localparam logic [6*4-1:0] RSUP = `RS_RSUP_LIST;
   logic r_sup;
   always_comb begin
      r_sup = (`RS_NUM_RSUP == 0);
      for (int i = 0; i < `RS_NUM_RSUP; i++)
         if (RSUP[6*i +: 6] == sel_r) r_sup = 1'b1;
   end
   // 255 = 3*5*17, so coprime means none of these divides h
   localparam bit H_OK = (`RS_SCALE_H % 3 != 0) && (`RS_SCALE_H % 5 != 0)
                      && (`RS_SCALE_H % 17 != 0) && (`RS_SCALE_H <= 255);
   wire punct_ok = (`RS_NUM_PUNCT == 0) || (ctrl_data.punct < 4'(`RS_NUM_PUNCT));
   wire cfg_ok = H_OK && r_sup && punct_ok && (`RS_SYM_W >= 3) && (`RS_SYM_W <= 12)
              && (sel_n >= 8'(`RS_MIN_N))
              && (sel_r >= 6'(`RS_MIN_R)) && (sel_r <= 6'(R))
              && ({2'b00, sel_r} < sel_n);
   wire idle_go = (state_q == rs_types_pkg::ST_IDLE) && clk_en && (!var_len || ctrl_valid);
   assign ctrl_ready = (state_q == rs_types_pkg::ST_IDLE) && var_len && clk_en;

   // -----------------------------------------------------------------
   // Root and locator constants
   // -----------------------------------------------------------------
   rs_types_pkg::sym_type ah;
   rs_types_pkg::sym_type root [0:R-1];
   rs_types_pkg::sym_type step [0:R];
   assign ah = gf_pow(8'h02, 8'(`RS_SCALE_H));
   for (genvar j = 0; j < R; j++) begin : g_root
      assign root[j] = gf_pow(ah, 8'(`RS_GEN_START + j));
   end
   for (genvar j = 0; j <= R; j++) begin : g_step
      assign step[j] = gf_pow(ah, 8'(j));
   end

   // Received symbol degree and its locator
   wire [7:0] deg = n_q - 8'h01 - idx_q;
   rs_types_pkg::sym_type xloc;
   assign xloc = gf_pow(ah, deg);
   wire [7:0] k_q = n_q - {2'b00, r_q};
   assign in_ready = (state_q == rs_types_pkg::ST_COLLECT) && clk_en;
   wire take = in_valid && in_ready;
   wire last_in = (idx_q == n_q - 8'h01);

   // -----------------------------------------------------------------
   // Berlekamp-Massey step, erasures preloaded in the locator
   // -----------------------------------------------------------------
   rs_types_pkg::sym_type disc;
   always_comb begin
      disc = '0;
      for (int i = 0; i < R; i++)
         if (i <= int'(rr_q) && int'(rr_q) - i < R)
            disc = disc ^ gf_mul(lam_q[i], syn_q[int'(rr_q) - i]);
   end
   rs_types_pkg::sym_type dinv;
   assign dinv = gf_inv(disc);
   wire bm_done = (rr_q >= r_q) || (ers_q >= {2'b00, r_q});
   wire grow = (disc != '0) && ({1'b0, len_q, 1'b0} <= {1'b0, rr_q} + ers_q);

   // Evaluator and Chien start values, one wide cycle at BM exit
   rs_types_pkg::sym_type xinv0;
   rs_types_pkg::sym_type om [0:R-1];
   rs_types_pkg::sym_type lt0 [0:R];
   assign xinv0 = gf_inv(gf_pow(ah, n_q - 8'h01));
   always_comb begin
      for (int j = 0; j < R; j++) begin
         om[j] = '0;
         for (int i = 0; i <= j; i++)
            if (j < int'(r_q)) om[j] = om[j] ^ gf_mul(lam_q[i], syn_q[j - i]);
      end
      for (int j = 0; j <= R; j++)
         lt0[j] = gf_mul(lam_q[j], gf_pow(xinv0, 8'(j)));
   end

   // -----------------------------------------------------------------
   // Chien search and Forney value
   // -----------------------------------------------------------------
   rs_types_pkg::sym_type lam_val, odd_val, om_val, err_val;
   always_comb begin
      lam_val = '0;
      odd_val = '0;
      om_val  = '0;
      for (int j = 0; j <= R; j++) begin
         lam_val = lam_val ^ lt_q[j];
         if (j % 2 == 1) odd_val = odd_val ^ lt_q[j];
         if (j < R) om_val = om_val ^ ot_q[j];
      end
   end
   // Odd part equals X^-1 times the derivative, so X cancels here
   assign err_val = gf_mul(gf_mul(om_val, gf_inv(odd_val)), gf_pow(xinv_q, 8'(`RS_GEN_START)));
   wire is_root = (lam_val == '0);
   wire [7:0] emit_n = out_parity ? n_q : k_q;
   wire emit_last = (idx_q == emit_n - 8'h01);
   // Count includes this step's root, since fail is latched on the last scan step
   wire [7:0] roots_all = roots_q + 8'(is_root);
   // Roots short of the locator degree, or 2*errors + erasures over r, is a failure
   wire bad = (roots_all != {2'b00, len_q})
           || ({1'b0, len_q, 1'b0} - {1'b0, ers_q} > {3'b000, r_q});

   // -----------------------------------------------------------------
   // Output buffer
   // -----------------------------------------------------------------
   rs_types_pkg::out_type o_word;
   logic fifo_ready;
   logic fifo_valid;
   wire push = (state_q == rs_types_pkg::ST_EMIT) && clk_en;
   assign o_word.sym = fail_q ? rx_q[idx_q] : fix_q[idx_q];
   assign o_word.delayed_received_field = rx_q[idx_q];
   assign o_word.mark = mark_q[idx_q];
   assign o_word.chan = chan_q;
   assign o_word.info_last = (idx_q == k_q - 8'h01);
   assign o_word.last = emit_last;
   assign o_word.fail = fail_q;
   assign o_word.err_cnt = fail_q ? 6'h00 : roots_q[5:0];
   assign o_word.zero_to_one_corrections = fail_q ? 9'h000 : z2o_q;
   assign o_word.one_to_zero_corrections = fail_q ? 9'h000 : o2z_q;
   assign out_valid = fifo_valid && clk_en;

   sym_fifo #(
      .W ($bits(rs_types_pkg::out_type)),
      .D (`RS_FIFO_DEPTH)
   ) u_out_fifo (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .in_data   (o_word),
      .out_valid (fifo_valid),
      .out_ready (out_ready && clk_en),
      .out_data  (out_data)
   );

   // -----------------------------------------------------------------
   // Control machine and datapath registers
   // -----------------------------------------------------------------
   // One block at a time keeps the output in input order
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_q      <= rs_types_pkg::ST_IDLE;
         ctrl_invalid <= 1'b0;
         n_q          <= 8'(`RS_DEF_N);
         r_q          <= 6'(`RS_DEF_R);
         idx_q        <= '0;
         chan_q       <= '0;
         fail_q       <= 1'b0;
      end else if (clk_en) begin
         ctrl_invalid <= 1'b0;
         case (state_q)
            rs_types_pkg::ST_IDLE: if (idle_go) begin
               ctrl_invalid <= !cfg_ok;
               if (cfg_ok) state_q <= rs_types_pkg::ST_COLLECT;
               n_q   <= sel_n;
               r_q   <= sel_r;
               idx_q <= '0;
               ers_q <= '0;
               for (int j = 0; j < R; j++) syn_q[j] <= '0;
               for (int j = 0; j <= R; j++) lam_q[j] <= (j == 0) ? 8'h01 : 8'h00;
               for (int j = 0; j <= R; j++) bb_q[j] <= (j == 0) ? 8'h01 : 8'h00;
            end
            rs_types_pkg::ST_COLLECT: if (take) begin
               rx_q[idx_q]   <= in_data.sym;
               mark_q[idx_q] <= in_data.mark;
               for (int j = 0; j < R; j++)
                  if (j < int'(r_q)) syn_q[j] <= gf_mul(syn_q[j], root[j]) ^ in_data.sym;
               // Erasure locator grows by (1 + X x) per erased symbol
               if (in_data.erase && ers_q < {2'b00, r_q}) begin
                  ers_q <= ers_q + 8'h01;
                  for (int j = 1; j <= R; j++) begin
                     lam_q[j] <= lam_q[j] ^ gf_mul(xloc, lam_q[j-1]);
                     bb_q[j]  <= bb_q[j] ^ gf_mul(xloc, bb_q[j-1]);
                  end
               end
               idx_q <= idx_q + 8'h01;
               if (last_in) begin
                  state_q <= rs_types_pkg::ST_BM;
                  rr_q    <= ers_q[5:0] + 6'(in_data.erase && ers_q < {2'b00, r_q});
                  len_q   <= ers_q[5:0] + 6'(in_data.erase && ers_q < {2'b00, r_q});
               end
            end
            rs_types_pkg::ST_BM: if (bm_done) begin
               state_q <= rs_types_pkg::ST_SCAN;
               for (int j = 0; j <= R; j++) lt_q[j] <= lt0[j];
               for (int j = 0; j < R; j++) ot_q[j] <= gf_mul(om[j], gf_pow(xinv0, 8'(j)));
               xinv_q  <= xinv0;
               idx_q   <= '0;
               roots_q <= '0;
               z2o_q   <= '0;
               o2z_q   <= '0;
            end else begin
               rr_q <= rr_q + 6'h01;
               for (int j = 0; j <= R; j++) begin
                  if (disc != '0)
                     lam_q[j] <= lam_q[j] ^ ((j > 0) ? gf_mul(disc, bb_q[j-1]) : 8'h00);
                  bb_q[j] <= grow ? gf_mul(dinv, lam_q[j]) : ((j > 0) ? bb_q[j-1] : 8'h00);
               end
               if (grow) len_q <= rr_q + 6'h01 + ers_q[5:0] - len_q;
            end
            rs_types_pkg::ST_SCAN: begin
               fix_q[idx_q] <= rx_q[idx_q] ^ (is_root ? err_val : 8'h00);
               if (is_root) begin
                  roots_q <= roots_q + 8'h01;
                  z2o_q <= z2o_q + 9'(ones(~rx_q[idx_q] & err_val));
                  o2z_q <= o2z_q + 9'(ones(rx_q[idx_q] & err_val));
               end
               for (int j = 0; j <= R; j++) lt_q[j] <= gf_mul(lt_q[j], step[j]);
               for (int j = 0; j < R; j++) ot_q[j] <= gf_mul(ot_q[j], step[j]);
               xinv_q <= gf_mul(xinv_q, ah);
               idx_q  <= idx_q + 8'h01;
               if (last_in) begin
                  state_q <= rs_types_pkg::ST_EMIT;
                  idx_q   <= '0;
                  fail_q  <= bad;
               end
            end
            rs_types_pkg::ST_EMIT: begin
               if (fifo_ready) begin
                  idx_q <= idx_q + 8'h01;
                  if (emit_last) begin
                     state_q <= rs_types_pkg::ST_IDLE;
                     chan_q <= (chan_q == 7'(`RS_CHANNELS - 1)) ? 7'h00 : chan_q + 7'h01;
                  end
               end
            end
            default: state_q <= rs_types_pkg::ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: verilog/sym_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`default_nettype none
module sym_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_q [0:D-1];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   wire           push = in_valid & in_ready;
   wire           pop  = out_valid & out_ready;

   // Honest flags straight from the occupancy count
   assign in_ready  = (cnt_q != (AW+1)'(D));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];

   // Pointers wrap at D; D is a power of two here
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) mem_q[wr_q] <= in_data;
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire
